// *** bitbang_params.svh ***
// Timing and reset constants for the bit-bang parallel port.
// Assumes inclusion by bare name from the package and the design file.
`ifndef BITBANG_PARAMS_SVH
`define BITBANG_PARAMS_SVH
`define BB_DATA_W 8
`define BB_FIFO_DEPTH 8
`define BB_DIR_RESET 8'h00
`define BB_OUT_RESET 8'h00
`define BB_CLK_MHZ 40
`define BB_ASYNC_PERIOD_NS 1000
`define BB_ASYNC_DIV ((`BB_ASYNC_PERIOD_NS * `BB_CLK_MHZ) / 1000)
`define BB_MODE_ASYNC 1'b0
`define BB_MODE_SYNC 1'b1
`endif

// *** bitbang_pkg.sv ***
// Types shared by the bit-bang parallel port.
// Assumes bitbang_params.svh is on the include path.
`include "bitbang_params.svh"
package bitbang_pkg;
  // One host byte with its per-line direction mask
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
  } host_word_t;

  // Port configuration
  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic wake_enable;
  } port_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DRIVE = 2'b01,
    ST_SAMPLE = 2'b10
  } bb_state_t;
endpackage

// *** bitbang_fifo.sv ***
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
module bitbang_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Sync reset, low
  input wire logic [WIDTH-1:0] wr_data_in, // Fill data
  input wire logic wr_valid_in, // Fill valid
  output logic wr_ready_out, // Not full
  output logic [WIDTH-1:0] rd_data_out, // Head word
  output logic rd_valid_out, // Not empty
  input wire logic rd_ready_in // Drain
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wptr_ff, rptr_ff;
  logic [AW:0] count_ff;
  logic do_wr, do_rd;

  // Handshakes
  assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
  assign rd_valid_out = (count_ff != '0);
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = rd_ready_in & rd_valid_out;
  assign rd_data_out = mem_ff[rptr_ff];

  // Storage
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_ff[wptr_ff] <= wr_data_in;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (do_wr) wptr_ff <= (wptr_ff == AW'(DEPTH-1)) ? '0 : wptr_ff + 1'b1;
      if (do_rd) rptr_ff <= (rptr_ff == AW'(DEPTH-1)) ? '0 : rptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // bitbang_fifo

// *** bitbang_port.sv ***
// Bit-bang parallel port of one channel: host bytes go out on the
// eight lines, line samples return to the host.
// Assumes the USB core supplies bytes, takes samples and handles resume.
//
// Behaviour
// - Bit-bang enable turns the eight lines into one bidirectional byte bus.
// - Synchronous and asynchronous variants, chosen by configuration, same pins.
// - Low write strobe marks new host data placed on the lines.
// - Rising edge of read strobe marks lines sampled and sent to host.
// - Suspended with wake enabled, low flush/wake input requests resume.
// - Not suspended, low flush/wake input flushes transmit data on next IN.
`timescale 1ns/1ps
`include "bitbang_params.svh"
module bitbang_port
  import bitbang_pkg::*;
(
  input wire logic clk_in, // 40 MHz core clock
  input wire logic rst_n_in, // Sync reset, low
  input wire port_cfg_t cfg_in, // Mode configuration
  input wire host_word_t host_word_in, // Byte from host
  input wire logic host_valid_in, // Host byte valid
  output logic host_ready_out, // FIFO can take byte
  output logic [7:0] sample_data_out, // Byte to host
  output logic sample_valid_out, // Sample pulse
  input wire logic sample_ready_in, // Host side can take sample
  input wire logic [7:0] io_lines_in, // Pin levels
  output logic [7:0] io_lines_out, // Pin drive values
  output logic [7:0] io_lines_oe_out, // Pin drive enables
  output logic write_update_strobe_n_out, // New data on lines, low
  output logic sample_taken_strobe_n_out, // Rising edge: sample sent
  input wire logic flush_wake_request_n_in, // Flush or wake strobe, low
  input wire logic usb_configured_power_n_in, // 1 while suspended
  output logic resume_request_out, // Resume request pulse
  output logic flush_request_out // Send-immediate pulse
);
  // ****************************************
  // Data path
  // ****************************************
  host_word_t head;
  logic head_valid, head_take;
  logic [7:0] out_ff, dir_ff, sample_ff;
  logic wstb_n_ff, rstb_n_ff, svalid_ff, tick_ff, fw_prev_ff;
  logic resume_ff, flush_ff;
  logic [15:0] div_ff;
  bb_state_t state_ff;

  bitbang_fifo #(.WIDTH(16), .DEPTH(`BB_FIFO_DEPTH)) bitbang_fifo_i (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_data_in(host_word_in),
    .wr_valid_in(host_valid_in),
    .wr_ready_out(host_ready_out),
    .rd_data_out(head),
    .rd_valid_out(head_valid),
    .rd_ready_in(head_take)
  );

  // Async variant paces itself by a divider enable
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !cfg_in.enable) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (div_ff == 16'(`BB_ASYNC_DIV - 1)) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 16'h0001;
      tick_ff <= 1'b0;
    end
  end

  // Sync variant samples only when a host byte is driven; async free-runs
  assign head_take = cfg_in.enable && (state_ff == ST_IDLE) && head_valid
                     && sample_ready_in;

  // ****************************************
  // Transfer sequencer
  // ****************************************
  // Sync: idle -> sample lines; async: idle -> drive byte -> idle, or idle -> sample lines on tick
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      out_ff <= `BB_OUT_RESET;
      dir_ff <= `BB_DIR_RESET;
      sample_ff <= 8'h00;
      wstb_n_ff <= 1'b1;
      rstb_n_ff <= 1'b1;
      svalid_ff <= 1'b0;
    end else begin
      wstb_n_ff <= 1'b1;
      rstb_n_ff <= 1'b1;
      svalid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (!cfg_in.enable) begin
            dir_ff <= `BB_DIR_RESET;
          end else if (head_take) begin
            out_ff <= head.data;
            dir_ff <= head.dir;
            wstb_n_ff <= 1'b0;
            state_ff <= (cfg_in.sync_mode == `BB_MODE_SYNC) ? ST_SAMPLE : ST_DRIVE;
          end else if (cfg_in.sync_mode == `BB_MODE_ASYNC && tick_ff && sample_ready_in) begin
            state_ff <= ST_SAMPLE;
          end
        end
        ST_DRIVE: begin
          state_ff <= ST_IDLE;
        end
        ST_SAMPLE: begin
          sample_ff <= io_lines_in;
          svalid_ff <= 1'b1;
          rstb_n_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  assign io_lines_out = out_ff;
  assign io_lines_oe_out = cfg_in.enable ? dir_ff : 8'h00;
  assign write_update_strobe_n_out = wstb_n_ff;
  assign sample_taken_strobe_n_out = rstb_n_ff;
  assign sample_data_out = sample_ff;
  assign sample_valid_out = svalid_ff;

  // ****************************************
  // Flush / wake input
  // ****************************************
  // Falling edge of the input; idle high when unused
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fw_prev_ff <= 1'b1;
      resume_ff <= 1'b0;
      flush_ff <= 1'b0;
    end else begin
      fw_prev_ff <= flush_wake_request_n_in;
      resume_ff <= fw_prev_ff && !flush_wake_request_n_in
                   && usb_configured_power_n_in && cfg_in.wake_enable;
      flush_ff <= fw_prev_ff && !flush_wake_request_n_in
                  && !usb_configured_power_n_in;
    end
  end

  assign resume_request_out = resume_ff;
  assign flush_request_out = flush_ff;
endmodule // bitbang_port

// *** bitbang_port_asserts.sv ***
// Checker: strobe, pulse and enable timing of the port.
// Assumes a bind into bitbang_port.
`timescale 1ns/1ps
module bitbang_port_asserts
  import bitbang_pkg::*;
(
  input logic clk_in, // Clock
  input logic rst_n_in, // Reset
  input port_cfg_t cfg_in, // Mode
  input logic [7:0] io_lines_oe_out, // Enables
  input logic write_update_strobe_n_out, // Strobe
  input logic sample_taken_strobe_n_out, // Strobe
  input logic sample_valid_out, // Sample
  input logic flush_wake_request_n_in, // Wake
  input logic usb_configured_power_n_in, // Suspend
  input logic resume_request_out, // Resume
  input logic flush_request_out // Flush
);
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_oe_gated:
  assert property (!cfg_in.enable |-> io_lines_oe_out == 8'h00) else $error("oe");
  a_wstb_one:
  assert property (!write_update_strobe_n_out |=> write_update_strobe_n_out) else $error("w");
  a_rstb_rise:
  assert property ($fell(sample_taken_strobe_n_out) |=> $rose(sample_taken_strobe_n_out))
    else $error("r");
  a_sync_sample:
  assert property (cfg_in.sync_mode && $fell(write_update_strobe_n_out) |=> sample_valid_out)
    else $error("s");
  a_flush_pulse:
  assert property ($fell(flush_wake_request_n_in) && !usb_configured_power_n_in
    |=> flush_request_out) else $error("f");
  a_resume_pulse:
  assert property ($fell(flush_wake_request_n_in) && usb_configured_power_n_in
    && cfg_in.wake_enable |=> resume_request_out) else $error("u");
  a_no_wake:
  assert property (!cfg_in.wake_enable |=> !resume_request_out) else $error("no wake");
  a_no_flush:
  assert property (usb_configured_power_n_in |=> !flush_request_out) else $error("no flush");
  a_reset_idle:
  assert property (disable iff (1'b0) !rst_n_in |=> write_update_strobe_n_out
    && sample_taken_strobe_n_out && io_lines_oe_out == 8'h00) else $error("i");
  cover property (resume_request_out);
  cover property (flush_request_out);
  cover property (!cfg_in.sync_mode && sample_valid_out);
  cover property (cfg_in.sync_mode && sample_valid_out);
endmodule // bitbang_port_asserts
bind bitbang_port bitbang_port_asserts bitbang_port_asserts_i (.*);

// *** bitbang_far_end.sv ***
// Far-side logic: drives every line the port leaves free.
// Assumes the bench sets the far-side levels.
`timescale 1ns/1ps
module bitbang_far_end (
  input wire logic [7:0] drive_in, // Port values
  input wire logic [7:0] oe_in, // Port enables
  input wire logic [7:0] far_in, // Far levels
  output logic [7:0] level_out // Line levels
);
  // Each line follows whoever drives it
  assign level_out = (drive_in & oe_in) | (far_in & ~oe_in);
endmodule // bitbang_far_end

// *** usb_bit_bang_parallel_port_tb.sv ***
// Bench: byte table, async sampling, fill and drain, flush and wake.
// Assumes the design files and the far-side model compile first.
`timescale 1ns/1ps
module usb_bit_bang_parallel_port_tb;
  import bitbang_pkg::*;
  logic clk_in, rst_n_in, host_valid_in, host_ready_out, sample_valid_out, sample_ready_in;
  logic write_update_strobe_n_out, sample_taken_strobe_n_out, flush_wake_request_n_in;
  logic usb_configured_power_n_in, resume_request_out, flush_request_out;
  logic [7:0] sample_data_out, io_lines_in, io_lines_out, io_lines_oe_out, far;
  port_cfg_t cfg_in;
  host_word_t host_word_in;
  logic [31:0] rows [3] = '{32'hFFA53CA5, 32'h0F96C3C6, 32'h00115A5A};
  int err_total, checks_done, k, n;
  bitbang_port bitbang_port_i (.*);
  bitbang_far_end bitbang_far_end_i (.drive_in(io_lines_out), .oe_in(io_lines_oe_out),
    .far_in(far), .level_out(io_lines_in));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic chk(input string s, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Bounded wait for a level
  task automatic wt(ref logic s, input logic v);
    for (int i = 0; i < 60 && s !== v; i++) @(negedge clk_in);
    chk("wait", {7'h00, v}, {7'h00, s});
    if (s !== v) give_verdict();
  endtask
  task automatic give_verdict;
    $display("err_total %0d checks_done %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reset, byte table, then the awkward cases
  initial begin
    {rst_n_in, host_valid_in, host_word_in, far} = '0;
    {sample_ready_in, flush_wake_request_n_in, usb_configured_power_n_in} = 3'h6;
    cfg_in = 3'h7;
    repeat (10) @(negedge clk_in);
    chk("idle", 8'h03, {6'h00, write_update_strobe_n_out, sample_taken_strobe_n_out});
    rst_n_in = 1'b1;
    for (k = 0; k < 3; k++) begin
      far = rows[k][15:8];
      host_word_in = rows[k][31:16];
      host_valid_in = 1'b1;
      wt(host_ready_out, 1'b1);
      @(negedge clk_in) host_valid_in = 1'b0;
      wt(write_update_strobe_n_out, 1'b0);
      chk("oe", rows[k][31:24], io_lines_oe_out);
      chk("lines", rows[k][23:16], io_lines_out);
      wt(sample_valid_out, 1'b1);
      chk("sample", rows[k][7:0], sample_data_out);
      chk("sample_taken_strobe_n", 8'h00, {7'h00, sample_taken_strobe_n_out});
    end
    cfg_in.sync_mode = 1'b0;
    @(negedge clk_in);
    wt(sample_valid_out, 1'b1);
    chk("async", 8'h5A, sample_data_out);
    {cfg_in.sync_mode, sample_ready_in, host_valid_in} = 3'h5;
    for (k = 0; k < 8; k++) begin
      host_word_in = {8'hFF, k[7:0]};
      wt(host_ready_out, 1'b1);
      @(negedge clk_in);
    end
    host_valid_in = 1'b0;
    chk("full", 8'h00, {7'h00, host_ready_out});
    sample_ready_in = 1'b1;
    n = 0;
    repeat (60) @(negedge clk_in) n += !write_update_strobe_n_out;
    chk("drained", 8'h08, n[7:0]);
    cfg_in.enable = 1'b0;
    @(negedge clk_in);
    chk("off", 8'h00, io_lines_oe_out);
    cfg_in.enable = 1'b1;
    for (k = 0; k < 3; k++) begin
      usb_configured_power_n_in = (k != 0);
      cfg_in.wake_enable = (k != 2);
      flush_wake_request_n_in = 1'b0;
      @(negedge clk_in) flush_wake_request_n_in = 1'b1;
      if (k == 0) wt(flush_request_out, 1'b1);
      else if (k == 1) wt(resume_request_out, 1'b1);
      else chk("nowake", 8'h00, {6'h00, resume_request_out, flush_request_out});
      @(negedge clk_in) chk("pulse", 8'h00, {6'h00, resume_request_out, flush_request_out});
    end
    // Reset in mid-run with a byte in flight
    host_word_in = 16'hFF3C;
    host_valid_in = 1'b1;
    @(negedge clk_in);
    {rst_n_in, host_valid_in} = 2'h0;
    @(negedge clk_in);
    chk("reset", 8'h03, {6'h00, write_update_strobe_n_out, sample_taken_strobe_n_out});
    chk("reset_oe", 8'h00, io_lines_oe_out);
    rst_n_in = 1'b1;
    n = 0;
    repeat (4) @(negedge clk_in) n += !write_update_strobe_n_out;
    chk("flushed", 8'h00, n[7:0]);
    chk("reset_rdy", 8'h01, {7'h00, host_ready_out});
    give_verdict();
  end
endmodule // usb_bit_bang_parallel_port_tb
